/* File: src/mcuie_pkg.sv */
// Shared constants for the instruction execution core: phases, opcode
// classes, ALU operations and reset values.
// Assumes a single system clock and external program and data memories.
package mcuie_pkg;

    // ----------------------------------------------------------------
    // Sizes and reset values
    // ----------------------------------------------------------------
    localparam int          PC_W          = 12;
    localparam int          STACK_DEPTH   = 4;
    localparam int          ICYCLE_CLKS   = 4;
    localparam logic [11:0] PC_RESET      = 12'h000;
    localparam logic [7:0]  PCL_ADDR      = 8'h06;   // Data address of pc low byte

    // ----------------------------------------------------------------
    // Phases of one instruction cycle, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        PH_ADDR   = 4'h1,
        PH_LATCH  = 4'h2,
        PH_DECODE = 4'h4,
        PH_EXEC   = 4'h8
    } mcuie_phase_e;

    // ----------------------------------------------------------------
    // Opcode classes in bits 15:12 of the instruction word
    // ----------------------------------------------------------------
    localparam logic [3:0] CLS_MOV_A_M = 4'h0;
    localparam logic [3:0] CLS_MOV_M_A = 4'h1;
    localparam logic [3:0] CLS_MOV_A_X = 4'h2;
    localparam logic [3:0] CLS_ALU_M   = 4'h3;
    localparam logic [3:0] CLS_ALU_TOM = 4'h4;
    localparam logic [3:0] CLS_ALU_X   = 4'h5;
    localparam logic [3:0] CLS_UNARY   = 4'h6;
    localparam logic [3:0] CLS_SETB    = 4'h7;
    localparam logic [3:0] CLS_CLRB    = 4'h8;
    localparam logic [3:0] CLS_SKZ_BIT = 4'h9;
    localparam logic [3:0] CLS_SKS_BIT = 4'hA;
    localparam logic [3:0] CLS_SKZ_M   = 4'hB;
    localparam logic [3:0] CLS_JUMP    = 4'hC;
    localparam logic [3:0] CLS_CALL    = 4'hD;
    localparam logic [3:0] CLS_CTRL    = 4'hE;

    // Sub codes of the control class in bits 11:8
    localparam logic [3:0] CTRL_RET    = 4'h0;
    localparam logic [3:0] CTRL_RETURN_FROM_INTERRUPT_OP   = 4'h1;
    localparam logic [3:0] CTRL_TABRD  = 4'h2;

    // ----------------------------------------------------------------
    // ALU operations
    // ----------------------------------------------------------------
    localparam logic [3:0] OP_ADD  = 4'h0;
    localparam logic [3:0] OP_ADC  = 4'h1;
    localparam logic [3:0] OP_SUB  = 4'h2;
    localparam logic [3:0] OP_SBC  = 4'h3;
    localparam logic [3:0] OP_AND  = 4'h4;
    localparam logic [3:0] OP_OR   = 4'h5;
    localparam logic [3:0] OP_XOR  = 4'h6;
    localparam logic [3:0] OP_INC  = 4'h8;
    localparam logic [3:0] OP_DEC  = 4'h9;
    localparam logic [3:0] OP_CPL  = 4'hA;
    localparam logic [3:0] OP_RR   = 4'hB;
    localparam logic [3:0] OP_RL   = 4'hC;
    localparam logic [3:0] OP_RRC  = 4'hD;
    localparam logic [3:0] OP_RLC  = 4'hE;
    localparam logic [3:0] OP_CLR  = 4'hF;

endpackage

/* File: src/mcuie_alu_if.sv */
// Interface between the sequencer and its ALU.
// Assumes the ALU is purely combinational.
`timescale 1ns/10ps
interface mcuie_alu_if;
    logic [3:0] op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [7:0] res;
    logic       cout;
    logic       c_upd;
    logic       z_upd;

    modport core (output op, a, b, cin, input res, cout, c_upd, z_upd);
    modport alu  (input op, a, b, cin, output res, cout, c_upd, z_upd);
endinterface

/* File: src/mcuie_alu.sv */
// Combinational 8-bit ALU: add, subtract, logic, inc/dec, rotates.
// Assumes the caller holds accumulator on a and operand on b.
`timescale 1ns/10ps
module mcuie_alu (
    mcuie_alu_if.alu bus
);

    // ----------------------------------------------------------------
    // Operation select
    // ----------------------------------------------------------------
    always_comb begin
        logic [8:0] t;
        t         = 9'h000;
        bus.res   = 8'h00;
        bus.cout  = 1'b0;
        bus.c_upd = 1'b0;
        bus.z_upd = 1'b1;
        case (bus.op)
            mcuie_pkg::OP_ADD, mcuie_pkg::OP_ADC: begin
                t = {1'b0, bus.a} + {1'b0, bus.b}
                    + {8'h00, bus.cin & (bus.op == mcuie_pkg::OP_ADC)};
                bus.res   = t[7:0];
                bus.cout  = t[8];                  // Carry above 255
                bus.c_upd = 1'b1;
            end
            mcuie_pkg::OP_SUB, mcuie_pkg::OP_SBC: begin
                t = {1'b0, bus.a} - {1'b0, bus.b}
                    - {8'h00, bus.cin & (bus.op == mcuie_pkg::OP_SBC)};
                bus.res   = t[7:0];
                bus.cout  = t[8];                  // Borrow below 0
                bus.c_upd = 1'b1;
            end
            mcuie_pkg::OP_AND: bus.res = bus.a & bus.b;
            mcuie_pkg::OP_OR:  bus.res = bus.a | bus.b;
            mcuie_pkg::OP_XOR: bus.res = bus.a ^ bus.b;
            mcuie_pkg::OP_CPL: bus.res = ~bus.b;
            mcuie_pkg::OP_INC: bus.res = bus.b + 8'h01;
            mcuie_pkg::OP_DEC: bus.res = bus.b - 8'h01;
            mcuie_pkg::OP_RR: begin
                bus.res   = {bus.b[0], bus.b[7:1]};
                bus.z_upd = 1'b0;
            end
            mcuie_pkg::OP_RL: begin
                bus.res   = {bus.b[6:0], bus.b[7]};
                bus.z_upd = 1'b0;
            end
            mcuie_pkg::OP_RRC: begin
                bus.res   = {bus.cin, bus.b[7:1]};
                bus.cout  = bus.b[0];
                bus.c_upd = 1'b1;
                bus.z_upd = 1'b0;
            end
            mcuie_pkg::OP_RLC: begin
                bus.res   = {bus.b[6:0], bus.cin};
                bus.cout  = bus.b[7];
                bus.c_upd = 1'b1;
                bus.z_upd = 1'b0;
            end
            mcuie_pkg::OP_CLR: bus.res = 8'h00;
            default:           bus.z_upd = 1'b0;         // Unused codes leave flags
        endcase
    end

endmodule // mcuie_alu

/* File: src/mcuie_core.sv */
// Instruction sequencer and execution core of the 8-bit controller.
// Assumes program and data memories on the same clock, with read data
// valid combinationally from the address this core drives.
`timescale 1ns/10ps
// How it works
// - Every instruction cycle is built from four system clock phases.
// - Plain instructions take one instruction cycle; jump, call, return and table read take two.
// - Writing the pc low byte jumps to the new address and costs one extra cycle.
// - A skip test that does not skip takes one cycle; a skip that fires takes one more.
// - Data moves cover register to accumulator, accumulator to register and constant to accumulator.
// - Adds flag carry above 255 and subtracts flag borrow below 0 in the carry bit.
// - Increment and decrement change the operand by exactly one, to memory or accumulator.
// - AND, OR, XOR and complement set the zero flag on a zero result, to memory or accumulator.
// - Rotates move one bit; through-carry rotates swap the outgoing bit with the carry.
// - Return resumes right after the call; a jump keeps no return address.
// - Conditional branches test a location or bit and go on or skip the next instruction.
// - Bit set and clear change one bit of a location by read-modify-write.
// - Table read fetches a program memory word and writes its low byte to the addressed data location.
module mcuie_core #(
    parameter int PC_W  = mcuie_pkg::PC_W,
    parameter int DEPTH = mcuie_pkg::STACK_DEPTH
) (
    input  wire logic            clk,
    input  wire logic            rst_b,
    output      logic [PC_W-1:0] pm_addr,
    input  wire logic [15:0]     pm_data,
    output      logic [7:0]      dm_addr,
    output      logic [7:0]      dm_wdata,
    output      logic            dm_we,
    input  wire logic [7:0]      dm_rdata,
    output      logic [7:0]      acc,
    output      logic            carry,
    output      logic            zero,
    output      logic [PC_W-1:0] pc,
    output      logic            inst_done
);

    localparam int SPW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        mcuie_pkg::mcuie_phase_e       phase;
        logic                          dummy;    // Second instruction cycle
        logic                          tbl;      // Second cycle fetches table word
        logic [15:0]                   instr;
        logic [PC_W-1:0]               pc;
        logic [7:0]                    acc;
        logic                          c;
        logic                          z;
        logic [7:0]                    opnd;     // Operand seen at execute
        logic [SPW-1:0]                sp;
        logic [DEPTH-1:0][PC_W-1:0]    stack;
        logic [PC_W-1:0]               pm_addr;
        logic [7:0]                    dm_addr;
        logic [7:0]                    dm_wdata;
        logic                          dm_we;
        logic                          done;
    } mcuie_state_s;

    mcuie_state_s st;
    mcuie_state_s next_st;
    mcuie_alu_if  alu_bus ();

    // Mask of one selected bit, used by set, clear and bit skips
    function automatic logic [7:0] bit_mask(input logic [2:0] i);
        bit_mask = 8'h01 << i;
    endfunction

    // ----------------------------------------------------------------
    // Operand and ALU hookup
    // ----------------------------------------------------------------
    logic [3:0] cls;
    logic [7:0] opnd;
    assign cls  = st.instr[15:12];
    // Reading the pc low byte sees the live counter, not memory
    assign opnd = (st.dm_addr == mcuie_pkg::PCL_ADDR) ? st.pc[7:0] : dm_rdata;
    assign alu_bus.a   = st.acc;
    assign alu_bus.b   = (cls == mcuie_pkg::CLS_ALU_X) ? st.instr[7:0] : opnd;
    assign alu_bus.cin = st.c;
    assign alu_bus.op  = {cls == mcuie_pkg::CLS_UNARY, st.instr[10:8]};

    mcuie_alu u_alu (
        .bus (alu_bus.alu)
    );

    // ----------------------------------------------------------------
    // Sequencer and execute
    // ----------------------------------------------------------------
    always_comb begin
        logic            wr;
        logic [7:0]      wv;
        logic            flags;
        logic            skip;
        logic [PC_W-1:0] pc_inc;
        logic [SPW-1:0]  sp_dn;
        wr      = 1'b0;
        wv      = 8'h00;
        flags   = 1'b0;
        skip    = 1'b0;
        pc_inc  = st.pc + 1'b1;
        sp_dn   = (st.sp == '0) ? SPW'(DEPTH - 1) : st.sp - 1'b1;
        next_st = st;
        next_st.dm_we = 1'b0;
        next_st.done  = 1'b0;
        case (st.phase)
            mcuie_pkg::PH_ADDR: next_st.phase = mcuie_pkg::PH_LATCH;
            mcuie_pkg::PH_LATCH: begin
                next_st.phase = mcuie_pkg::PH_DECODE;
                if (!st.dummy) begin
                    next_st.instr   = pm_data;
                    next_st.dm_addr = pm_data[7:0];
                end else if (st.tbl) begin
                    next_st.dm_wdata = pm_data[7:0];
                    next_st.dm_we    = 1'b1;
                end
            end
            mcuie_pkg::PH_DECODE: next_st.phase = mcuie_pkg::PH_EXEC;
            mcuie_pkg::PH_EXEC: begin
                next_st.phase = mcuie_pkg::PH_ADDR;
                if (st.dummy) begin
                    // Spare cycle ends; fetch resumes at the settled pc
                    next_st.dummy   = 1'b0;
                    next_st.tbl     = 1'b0;
                    next_st.pm_addr = st.pc;
                end else begin
                    next_st.done = 1'b1;
                    next_st.opnd = opnd;
                    next_st.pc   = pc_inc;
                    case (cls)
                        mcuie_pkg::CLS_MOV_A_M: next_st.acc = opnd;
                        mcuie_pkg::CLS_MOV_A_X: next_st.acc = st.instr[7:0];
                        mcuie_pkg::CLS_MOV_M_A: begin
                            wr = 1'b1;
                            wv = st.acc;
                        end
                        mcuie_pkg::CLS_ALU_M, mcuie_pkg::CLS_ALU_X: begin
                            next_st.acc = alu_bus.res;
                            flags       = 1'b1;
                        end
                        mcuie_pkg::CLS_ALU_TOM: begin
                            wr    = 1'b1;
                            wv    = alu_bus.res;
                            flags = 1'b1;
                        end
                        mcuie_pkg::CLS_UNARY: begin
                            flags = 1'b1;
                            if (st.instr[11]) begin
                                next_st.acc = alu_bus.res;
                            end else begin
                                wr = 1'b1;
                                wv = alu_bus.res;
                            end
                        end
                        mcuie_pkg::CLS_SETB: begin
                            wr = 1'b1;
                            wv = opnd | bit_mask(st.instr[10:8]);
                        end
                        mcuie_pkg::CLS_CLRB: begin
                            wr = 1'b1;
                            wv = opnd & ~bit_mask(st.instr[10:8]);
                        end
                        mcuie_pkg::CLS_SKZ_BIT: skip = (opnd & bit_mask(st.instr[10:8])) == 8'h00;
                        mcuie_pkg::CLS_SKS_BIT: skip = (opnd & bit_mask(st.instr[10:8])) != 8'h00;
                        mcuie_pkg::CLS_SKZ_M:   skip = (opnd == 8'h00);
                        mcuie_pkg::CLS_JUMP: begin
                            next_st.pc    = st.instr[PC_W-1:0];
                            next_st.dummy = 1'b1;
                        end
                        mcuie_pkg::CLS_CALL: begin
                            next_st.stack[st.sp] = pc_inc;
                            next_st.sp    = (st.sp == SPW'(DEPTH - 1)) ? '0 : st.sp + 1'b1;
                            next_st.pc    = st.instr[PC_W-1:0];
                            next_st.dummy = 1'b1;
                        end
                        mcuie_pkg::CLS_CTRL: begin
                            if (st.instr[11:8] == mcuie_pkg::CTRL_RET
                                || st.instr[11:8] == mcuie_pkg::CTRL_RETURN_FROM_INTERRUPT_OP) begin
                                next_st.sp    = sp_dn;
                                next_st.pc    = st.stack[sp_dn];
                                next_st.dummy = 1'b1;
                            end else if (st.instr[11:8] == mcuie_pkg::CTRL_TABRD) begin
                                next_st.dummy = 1'b1;
                                next_st.tbl   = 1'b1;
                            end
                        end
                        default: ;                                            // No operation
                    endcase
                    if (flags && alu_bus.c_upd) next_st.c = alu_bus.cout;
                    if (flags && alu_bus.z_upd) next_st.z = (alu_bus.res == 8'h00);
                    if (skip) begin
                        next_st.pc    = st.pc + 2'h2;
                        next_st.dummy = 1'b1;
                    end
                    // Low pc byte is a register here, so a write to it is a jump
                    if (wr && st.dm_addr == mcuie_pkg::PCL_ADDR) begin
                        next_st.pc    = {st.pc[PC_W-1:8], wv};
                        next_st.dummy = 1'b1;
                    end else if (wr) begin
                        next_st.dm_wdata = wv;
                        next_st.dm_we    = 1'b1;
                    end
                    // Table page is the current pc page, index is the accumulator
                    next_st.pm_addr = next_st.tbl ? {st.pc[PC_W-1:8], st.acc} : next_st.pc;
                end
            end
            default: next_st.phase = mcuie_pkg::PH_ADDR;
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st         <= '0;
            st.phase   <= mcuie_pkg::PH_ADDR;
            st.pc      <= PC_W'(mcuie_pkg::PC_RESET);
            st.pm_addr <= PC_W'(mcuie_pkg::PC_RESET);
        end else begin
            st <= next_st;
        end
    end

    assign pm_addr   = st.pm_addr;
    assign dm_addr   = st.dm_addr;
    assign dm_wdata  = st.dm_wdata;
    assign dm_we     = st.dm_we;
    assign acc       = st.acc;
    assign carry     = st.c;
    assign zero      = st.z;
    assign pc        = st.pc;
    assign inst_done = st.done;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_idle3;
        !st.done [*3];
    endsequence
    sequence s_idle7;
        s_idle3 ##1 !st.done [*4];
    endsequence

    property p_icycle;
        st.done |-> ##1 s_idle3;
    endproperty
    a_icycle: assert property (p_icycle) else $error("done closer than 4 clocks");

    property p_single;
        st.done && !st.dummy |-> ##4 st.done;
    endproperty
    a_single: assert property (p_single) else $error("one-cycle op not 4 clocks");

    property p_jump;
        st.done && st.instr[15:12] == mcuie_pkg::CLS_JUMP
            |-> st.pc == st.instr[PC_W-1:0] && st.dummy ##1 s_idle7 ##1 st.done;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target or timing wrong");

    property p_pcl;
        st.done && st.instr[15:12] == mcuie_pkg::CLS_MOV_M_A
            && st.instr[7:0] == mcuie_pkg::PCL_ADDR
            |-> st.pc[7:0] == st.acc && st.dummy && !st.dm_we;
    endproperty
    a_pcl: assert property (p_pcl) else $error("pc low write did not jump");

    property p_skip;
        st.done && st.instr[15:12] == mcuie_pkg::CLS_SKZ_M
            |-> (st.opnd == 8'h00) == st.dummy
                && st.pc == PC_W'($past(st.pc) + (st.dummy ? 2 : 1));
    endproperty
    a_skip: assert property (p_skip) else $error("skip pc or timing wrong");

    property p_mov;
        st.done && st.instr[15:12] == mcuie_pkg::CLS_MOV_A_X |-> st.acc == st.instr[7:0];
    endproperty
    a_mov: assert property (p_mov) else $error("immediate move wrong");

    property p_add;
        st.done && st.instr[15:12] == mcuie_pkg::CLS_ALU_M
            && st.instr[10:8] == mcuie_pkg::OP_ADD[2:0]
            |-> {st.c, st.acc} == {1'b0, $past(st.acc)} + {1'b0, st.opnd};
    endproperty
    a_add: assert property (p_add) else $error("add sum or carry wrong");

    property p_inc;
        st.done && st.instr[15:11] == {mcuie_pkg::CLS_UNARY, 1'b1}
            && st.instr[10:8] == mcuie_pkg::OP_INC[2:0]
            |-> st.acc == 8'(st.opnd + 8'h01);
    endproperty
    a_inc: assert property (p_inc) else $error("increment not by one");

    property p_zero;
        st.done && st.instr[15:12] == mcuie_pkg::CLS_ALU_X
            && st.instr[10:8] == mcuie_pkg::OP_AND[2:0]
            |-> st.z == (st.acc == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong after and");

    property p_rlc;
        st.done && st.instr[15:11] == {mcuie_pkg::CLS_UNARY, 1'b1}
            && st.instr[10:8] == mcuie_pkg::OP_RLC[2:0]
            |-> st.acc == {st.opnd[6:0], $past(st.c)} && st.c == st.opnd[7];
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate through carry wrong");

    property p_call;
        st.done && st.instr[15:12] == mcuie_pkg::CLS_CALL
            |-> st.stack[$past(st.sp)] == PC_W'($past(st.pc) + 1);
    endproperty
    a_call: assert property (p_call) else $error("call saved wrong address");

    property p_setb;
        st.done && st.instr[15:12] == mcuie_pkg::CLS_SETB
            && st.instr[7:0] != mcuie_pkg::PCL_ADDR
            |-> st.dm_we && st.dm_wdata == (st.opnd | bit_mask(st.instr[10:8]));
    endproperty
    a_setb: assert property (p_setb) else $error("bit set disturbed other bits");

    property p_tbl;
        st.done && st.instr[15:8] == {mcuie_pkg::CLS_CTRL, mcuie_pkg::CTRL_TABRD}
            |-> st.tbl ##2 st.dm_we;
    endproperty
    a_tbl: assert property (p_tbl) else $error("table word not written");

endmodule // mcuie_core

/* File: bench/mcu_instruction_execution_bench.sv */
// Bench for the execution core: a short program in modelled memories,
// one expected note per instruction, checked when inst_done pulses.
// Assumes both memories answer combinationally from the core's addresses.
`timescale 1ns/10ps
module mcu_instruction_execution_bench;
    typedef struct {
        logic [7:0]  a;
        logic        c;
        logic        z;
        logic [11:0] pc;
        int          gap;
    } mcuie_note_s;

    // ----------------------------------------------------------------
    // Signals and memories
    // ----------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [11:0] pm_addr, pc;
    logic [15:0] pm_data;
    logic [7:0]  dm_addr, dm_wdata, dm_rdata, acc;
    logic        dm_we, carry, zero, inst_done;
    logic [15:0] prog [4096];
    logic [7:0]  dm [256];
    mcuie_note_s q [$];
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          last = 0;
    logic [31:0] seed = 32'h0000003F;

    // Memories answer in the same clock, as the core expects
    assign pm_data  = prog[pm_addr];
    assign dm_rdata = dm[dm_addr];

    mcuie_core i_mcuie_core (.clk(clk), .rst_b(rst_b), .pm_addr(pm_addr), .pm_data(pm_data),
        .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata),
        .acc(acc), .carry(carry), .zero(zero), .pc(pc), .inst_done(inst_done));

    initial forever #5 clk = ~clk;

    // Data memory takes the write on the edge ending the strobe
    always @(posedge clk) if (dm_we === 1'b1) dm[dm_addr] <= dm_wdata;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Places one word and notes what the core must show after it
    task automatic put(logic [11:0] ad, logic [15:0] w, logic [7:0] a, logic c, logic z,
                       logic [11:0] p, int g);
        prog[ad] = w;
        q.push_back(mcuie_note_s'{a, c, z, p, g});
    endtask

    // Gap of zero marks the first instruction, whose spacing is undefined
    always @(posedge clk) begin
        mcuie_note_s e;
        cyc <= cyc + 1;
        if (inst_done === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            check("acc", acc, e.a);
            check("carry", carry, e.c);
            check("zero", zero, e.z);
            check("pc", pc, e.pc);
            if (e.gap != 0) check("gap", 16'(cyc - last), 16'(e.gap));
            last <= cyc;
        end
    end

    // ----------------------------------------------------------------
    // Program and run
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] r1, r2, s;
        logic [8:0] sum;
        int         n;
        foreach (prog[i]) prog[i] = 16'hF000;
        foreach (dm[i]) dm[i] = 8'h00;
        dm[8'h06] = 8'h5A;
        dm[8'h21] = 8'h80;
        r1  = xs();
        r2  = xs();
        sum = {1'b0, r1} + {1'b0, r2};
        s   = sum[7:0];
        put(12'h000, {8'h20, r1}, r1, 1'b0, 1'b0, 12'h001, 0);
        put(12'h001, {8'h50, r2}, s, sum[8], s == 8'h00, 12'h002, 4);
        put(12'h002, {8'h52, s}, 8'h00, 1'b0, 1'b1, 12'h003, 4);
        put(12'h003, 16'h5201, 8'hFF, 1'b1, 1'b0, 12'h004, 4);
        put(12'h004, 16'h1020, 8'hFF, 1'b1, 1'b0, 12'h005, 4);
        put(12'h005, 16'h6020, 8'hFF, 1'b1, 1'b1, 12'h006, 4);
        put(12'h006, 16'h6920, 8'hFF, 1'b1, 1'b0, 12'h007, 4);
        put(12'h007, 16'h6D21, 8'hC0, 1'b0, 1'b0, 12'h008, 4);
        put(12'h008, 16'h7021, 8'hC0, 1'b0, 1'b0, 12'h009, 4);
        put(12'h009, 16'h0021, 8'h81, 1'b0, 1'b0, 12'h00A, 4);
        put(12'h00A, 16'h9121, 8'h81, 1'b0, 1'b0, 12'h00C, 4);
        prog[12'h00B] = 16'h2000; // Would clear acc if the skip failed
        put(12'h00C, 16'hD040, 8'h81, 1'b0, 1'b0, 12'h040, 8);
        put(12'h040, 16'hE000, 8'h81, 1'b0, 1'b0, 12'h00D, 8);
        put(12'h00D, 16'hC050, 8'h81, 1'b0, 1'b0, 12'h050, 8);
        put(12'h050, 16'h1006, 8'h81, 1'b0, 1'b0, 12'h081, 8);
        put(12'h081, 16'h5400, 8'h00, 1'b0, 1'b1, 12'h082, 8);
        put(12'h082, 16'hE222, 8'h00, 1'b0, 1'b1, 12'h083, 4);
        put(12'h083, 16'h0022, r1, 1'b0, 1'b1, 12'h084, 8);
        // Memory add, inc and rotate to acc, word skips, interrupt return, bit clear
        sum = {1'b0, r1} + 9'h081;
        s   = {7'h01, sum[8]};
        put(12'h084, 16'h3021, sum[7:0], sum[8], sum[7:0] == 8'h00, 12'h085, 4);
        put(12'h085, 16'h6821, 8'h82, sum[8], 1'b0, 12'h086, 4);
        put(12'h086, 16'h6E21, s, 1'b1, 1'b0, 12'h087, 4);
        put(12'h087, 16'hB020, s, 1'b1, 1'b0, 12'h089, 4);
        put(12'h089, 16'hB021, s, 1'b1, 1'b0, 12'h08A, 8);
        put(12'h08A, 16'hD060, s, 1'b1, 1'b0, 12'h060, 4);
        put(12'h060, 16'hE100, s, 1'b1, 1'b0, 12'h08B, 8);
        put(12'h08B, 16'h8721, s, 1'b1, 1'b0, 12'h08C, 8);
        put(12'h08C, 16'hA021, s, 1'b1, 1'b0, 12'h08E, 4);
        put(12'h08E, 16'h4223, s, 1'b0, 1'b0, 12'h08F, 8);
        prog[12'h08F] = 16'hC08F;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (n = 0; n < 400 && q.size() > 0; n++) @(posedge clk);
        check("pending", 16'(q.size()), 16'h0000);
        // Last write lands on the edge that ends its strobe
        repeat (2) @(posedge clk);
        check("dm20", dm[8'h20], 8'h00);
        check("dm21", dm[8'h21], 8'h01);
        check("dm23", dm[8'h23], s);
        check("dm22", dm[8'h22], r1);
        check("dm06", dm[8'h06], 8'h5A);
        conclude();
    end
endmodule // mcu_instruction_execution_bench
